// ---- hae_engine.sv ----
// Purpose: Harmonic analysis engine: sequences component requests, applies
//          offsets, derives power, power factor and distortion ratios.
// Assumes: A same-clock filter bank answers each request with rms, P and Q.
// Notes:   Division and square root are iterative and shared by all slots.
//
// Design decisions made here: the APB register port and the address map.

`timescale 1ns/10ps

// Notes on behaviour
// - Frequency range 45 Hz to 66 Hz is checked and reported in status.
// - Harmonic count is floor(2800/f), limited to 63.
// - Index writes above 63 are refused; software keeps indices within 63.
// - Config bits 9:8 pick time-base phase A, B or C.
// - Changing the time-base phase restarts a round and keeps working.
// - Config bits 2:1 pick analysed phase A, B or C.
// - Value 11 analyses neutral current with the summed phase current.
// - Phase mode computes the fundamental and three harmonics per round.
// - Three 8-bit index registers hold the harmonic order of each slot.
// - Fundamental always computed in phase mode; index 1 repeats it.
// - Harmonics below 2800 Hz pass unattenuated; -3 dB at 3.3 kHz.
// - Fundamental voltage and current rms stored as 24-bit results.
// - Fundamental rms gets per-phase 24-bit voltage and current offsets.
// - Voltage and current rms of three harmonics go to six results.
// - Six 24-bit offsets correct the harmonic voltage and current rms.
// - Fundamental active, reactive, apparent power and power factor P/S.
// - Each harmonic gets active, reactive, apparent power and P/S.
// - THD is sqrt(total squared minus fundamental squared) over fundamental.
// - Harmonic distortion is harmonic rms over fundamental rms.
// - Neutral mode gives rms for three orders on both currents, and distortion only when index 0 is 1.
// - Distortion ratios are 3.21 signed, clamped at +3.9999.
module hae_engine
  import hae_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] line_freq,
  output logic      [1:0]  time_base_phase_select,
  output logic      [1:0]  analysed_channel_select,
  output logic             comp_req,
  output logic      [5:0]  comp_order,
  input  wire logic        comp_valid,
  input  wire logic [23:0] comp_vrms,
  input  wire logic [23:0] comp_irms,
  input  wire logic [23:0] comp_p,
  input  wire logic [23:0] comp_q,
  input  wire logic [23:0] total_vrms,
  input  wire logic [23:0] total_irms
);

  typedef struct packed {
    logic [15:0]            cfg;
    logic [2:0][7:0]        idx;
    logic [5:0][23:0]       poff;
    logic [5:0][23:0]       hoff;
    logic [3:0][7:0][23:0]  res;
    logic [5:0]             ncount;
    logic                   in_range;
    logic                   beyond;
    logic [7:0]             rounds;
    hae_state_type          st;
    hae_op_type             op;
    logic [1:0]             slot;
    logic [5:0]             order;
    logic [23:0]            tot_v;
    logic [23:0]            tot_i;
    logic [47:0]            num;
    logic [23:0]            den;
    logic [25:0]            rem;
    logic [23:0]            root;
    logic [5:0]             cnt;
    logic [31:0]            rdata;
  } hae_regs_type;

  hae_regs_type r_q;
  hae_regs_type r_d;
  logic         addr_hit;
  logic         addr_wr;
  logic [31:0]  rd_data;
  logic         idx_refused;
  logic         wr_en;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Offset-corrected rms never goes negative and never wraps past full scale.
  function automatic logic [23:0] sat_add(input logic [23:0] a, input logic [23:0] b);
    logic signed [24:0] s;
    s = $signed({a[23], a}) + $signed({b[23], b});
    if (s < 0) sat_add = '0;
    else if (s > $signed({1'b0, RES_MAX})) sat_add = RES_MAX;
    else sat_add = s[23:0];
  endfunction : sat_add

  function automatic logic [23:0] clamp_q(input logic [47:0] q);
    clamp_q = (q > {24'h00_0000, RES_MAX}) ? RES_MAX : q[23:0];
  endfunction : clamp_q

  function automatic logic [47:0] sq_diff(input logic [23:0] t, input logic [23:0] f);
    logic [47:0] tt;
    logic [47:0] ff;
    tt = {24'h00_0000, t} * {24'h00_0000, t};
    ff = {24'h00_0000, f} * {24'h00_0000, f};
    sq_diff = (tt > ff) ? tt - ff : '0;
  endfunction : sq_diff

  function automatic logic [5:0] order_of(input logic [1:0] s, input logic [2:0][7:0] ix);
    order_of = (s == 2'h0) ? ORDER_FUND : ix[s - 2'h1][5:0];
  endfunction : order_of

  // ---------------------------------------------------------------------------
  // APB address decode
  // ---------------------------------------------------------------------------
  always_comb begin
    addr_hit = 1'b1;
    addr_wr  = 1'b1;
    rd_data  = '0;
    if (paddr[1:0] != 2'h0) begin
      addr_hit = 1'b0;
    end else if (paddr == ADDR_CFG) begin
      rd_data = {16'h0000, r_q.cfg};
    end else if (paddr == ADDR_IDX0) begin
      rd_data = {24'h00_0000, r_q.idx[0]};
    end else if (paddr == ADDR_IDX1) begin
      rd_data = {24'h00_0000, r_q.idx[1]};
    end else if (paddr == ADDR_IDX2) begin
      rd_data = {24'h00_0000, r_q.idx[2]};
    end else if (paddr == ADDR_STATUS) begin
      addr_wr                    = 1'b0;
      rd_data[ST_BUSY]           = (r_q.st != S_IDLE);
      rd_data[ST_IN_RANGE]       = r_q.in_range;
      rd_data[ST_BEYOND]         = r_q.beyond;
      rd_data[ST_N_LSB +: 6]     = r_q.ncount;
      rd_data[ST_ROUND_LSB +: 8] = r_q.rounds;
    end else if (paddr >= ADDR_POFF && paddr <= ADDR_POFF_LAST) begin
      rd_data = {8'h00, r_q.poff[paddr[4:2]]};
    end else if (paddr >= ADDR_HOFF && paddr <= ADDR_HOFF_LAST) begin
      rd_data = {8'h00, r_q.hoff[paddr[4:2]]};
    end else if (paddr[11:7] == RES_PAGE) begin
      addr_wr = 1'b0;
      rd_data = {8'h00, r_q.res[paddr[6:5]][paddr[4:2]]};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // an index above the allowed maximum is refused and flagged.
  assign idx_refused = (paddr == ADDR_IDX0 || paddr == ADDR_IDX1 || paddr == ADDR_IDX2)
                       && pwrite && (pwdata[7:0] > IDX_MAX);
  assign wr_en       = psel && penable && pwrite && addr_hit && addr_wr && !idx_refused;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && (!addr_hit || idx_refused);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic        go_div;
    logic        go_sqrt;
    logic        adv;
    logic        restart;
    logic        neutral;
    logic [1:0]  ref_slot;
    logic [47:0] nxt_num;
    logic [23:0] nxt_den;
    hae_op_type  nxt_op;
    logic [23:0] vr;
    logic [23:0] ir;
    logic [23:0] off_v;
    logic [23:0] off_i;
    logic [47:0] prod;
    logic [23:0] absp;
    logic [23:0] q24;
    logic [25:0] rem_t;
    logic [25:0] trial;
    go_div   = 1'b0;
    go_sqrt  = 1'b0;
    adv      = 1'b0;
    restart  = 1'b0;
    neutral  = (r_q.cfg[CFG_CH_LSB +: 2] == CH_NEUTRAL);
    ref_slot = neutral ? 2'h1 : 2'h0;
    nxt_num  = '0;
    nxt_den  = '0;
    nxt_op   = OP_FREQ;
    vr       = '0;
    ir       = '0;
    off_v    = '0;
    off_i    = '0;
    prod     = '0;
    absp     = '0;
    q24      = clamp_q(r_q.num);
    rem_t    = '0;
    trial    = '0;
    r_d      = r_q;

    // Read data is captured in the setup phase, so reads need no wait state.
    if (psel && !penable) r_d.rdata = rd_data;

    if (wr_en) begin
      if (paddr == ADDR_CFG) begin
        r_d.cfg = pwdata[15:0] & CFG_WMASK;
        restart = 1'b1;
      end else if (paddr == ADDR_IDX0) begin
        r_d.idx[0] = pwdata[7:0];
        restart    = 1'b1;
      end else if (paddr == ADDR_IDX1) begin
        r_d.idx[1] = pwdata[7:0];
        restart    = 1'b1;
      end else if (paddr == ADDR_IDX2) begin
        r_d.idx[2] = pwdata[7:0];
        restart    = 1'b1;
      end else if (paddr >= ADDR_POFF && paddr <= ADDR_POFF_LAST) begin
        r_d.poff[paddr[4:2]] = pwdata[23:0];
      end else begin
        r_d.hoff[paddr[4:2]] = pwdata[23:0];
      end
    end

    case (r_q.st)
      S_IDLE: begin
        go_div  = 1'b1;
        nxt_num = FREQ_DIV_NUM;
        nxt_den = {8'h00, line_freq};
        nxt_op  = OP_FREQ;
      end
      S_REQ: begin
        if (r_q.slot == 2'h0) begin
          off_v = r_q.poff[{r_q.cfg[CFG_CH_LSB +: 2], 1'b0}];
          off_i = r_q.poff[{r_q.cfg[CFG_CH_LSB +: 2], 1'b1}];
        end else begin
          off_v = r_q.hoff[{r_q.slot - 2'h1, 1'b0}];
          off_i = r_q.hoff[{r_q.slot - 2'h1, 1'b1}];
        end
        vr = sat_add(comp_vrms, off_v);
        ir = sat_add(comp_irms, off_i);
        if (comp_valid) begin
          r_d.res[r_q.slot][F_VRMS] = vr;
          r_d.res[r_q.slot][F_IRMS] = ir;
          if (!neutral) begin
            r_d.res[r_q.slot][F_P] = comp_p;
            r_d.res[r_q.slot][F_Q] = comp_q;
            if (r_q.slot == 2'h0) begin
              r_d.tot_v = total_vrms;
              r_d.tot_i = total_irms;
            end
            r_d.st = S_POWER;
          end else if (r_q.idx[0] != {2'h0, ORDER_FUND}) begin
            adv = 1'b1;
          end else if (r_q.slot == 2'h1) begin
            r_d.res[1][F_HDV] = HD_ONE;
            r_d.res[1][F_HDI] = HD_ONE;
            adv               = 1'b1;
          end else begin
            go_div  = 1'b1;
            nxt_num = {3'h0, vr, 21'h00_0000};
            nxt_den = r_q.res[1][F_VRMS];
            nxt_op  = OP_HDV;
          end
        end
      end
      S_POWER: begin
        prod = {24'h00_0000, r_q.res[r_q.slot][F_VRMS]} * {24'h00_0000, r_q.res[r_q.slot][F_IRMS]};
        r_d.res[r_q.slot][F_S] = prod[46:23];
        absp    = r_q.res[r_q.slot][F_P][23] ? 24'(-r_q.res[r_q.slot][F_P])
                                             : r_q.res[r_q.slot][F_P];
        go_div  = 1'b1;
        nxt_num = {1'b0, absp, 23'h00_0000};
        nxt_den = prod[46:23];
        nxt_op  = OP_PF;
      end
      S_DIV: begin
        if (r_q.cnt != DIV_STEPS) begin
          rem_t   = {r_q.rem[24:0], r_q.num[47]};
          r_d.cnt = r_q.cnt + 6'h01;
          if (rem_t >= {2'h0, r_q.den}) begin
            r_d.rem = rem_t - {2'h0, r_q.den};
            r_d.num = {r_q.num[46:0], 1'b1};
          end else begin
            r_d.rem = rem_t;
            r_d.num = {r_q.num[46:0], 1'b0};
          end
        end else begin
          case (r_q.op)
            OP_FREQ: begin
              r_d.ncount   = (r_q.num > {42'h0, N_MAX}) ? N_MAX : r_q.num[5:0];
              r_d.in_range = (line_freq >= FREQ_MIN) && (line_freq <= FREQ_MAX);
              r_d.beyond   = 1'b0;
              for (int k = 0; k < 3; k++) begin
                if (r_q.idx[k] == 8'h00 || r_q.idx[k][5:0] > r_d.ncount) r_d.beyond = 1'b1;
              end
              r_d.slot  = ref_slot;
              r_d.order = order_of(ref_slot, r_q.idx);
              r_d.st    = S_REQ;
            end
            OP_PF: begin
              r_d.res[r_q.slot][F_PF] = r_q.res[r_q.slot][F_P][23] ? 24'(-q24) : q24;
              if (r_q.slot == 2'h0) begin
                go_sqrt = 1'b1;
                nxt_num = sq_diff(r_q.tot_v, r_q.res[0][F_VRMS]);
                nxt_op  = OP_THDV;
              end else begin
                go_div  = 1'b1;
                nxt_num = {3'h0, r_q.res[r_q.slot][F_VRMS], 21'h00_0000};
                nxt_den = r_q.res[ref_slot][F_VRMS];
                nxt_op  = OP_HDV;
              end
            end
            OP_HDV: begin
              r_d.res[r_q.slot][F_HDV] = q24;
              go_div  = 1'b1;
              nxt_num = {3'h0, r_q.res[r_q.slot][F_IRMS], 21'h00_0000};
              nxt_den = r_q.res[ref_slot][F_IRMS];
              nxt_op  = OP_HDI;
            end
            OP_HDI: begin
              r_d.res[r_q.slot][F_HDI] = q24;
              adv = 1'b1;
            end
            OP_THDV: begin
              r_d.res[0][F_HDV] = q24;
              go_sqrt = 1'b1;
              nxt_num = sq_diff(r_q.tot_i, r_q.res[0][F_IRMS]);
              nxt_op  = OP_THDI;
            end
            default: begin
              r_d.res[0][F_HDI] = q24;
              adv = 1'b1;
            end
          endcase
        end
      end
      S_SQRT: begin
        if (r_q.cnt != SQRT_STEPS) begin
          rem_t    = {r_q.rem[23:0], r_q.num[47:46]};
          trial    = {r_q.root, 2'h1};
          r_d.cnt  = r_q.cnt + 6'h01;
          r_d.num  = {r_q.num[45:0], 2'h0};
          if (rem_t >= trial) begin
            r_d.rem  = rem_t - trial;
            r_d.root = {r_q.root[22:0], 1'b1};
          end else begin
            r_d.rem  = rem_t;
            r_d.root = {r_q.root[22:0], 1'b0};
          end
        end else begin
          go_div  = 1'b1;
          nxt_num = {3'h0, r_q.root, 21'h00_0000};
          nxt_den = (r_q.op == OP_THDV) ? r_q.res[0][F_VRMS] : r_q.res[0][F_IRMS];
          nxt_op  = r_q.op;
        end
      end
      default: r_d.st = S_IDLE;
    endcase

    if (adv) begin
      if (r_q.slot == 2'h3) begin
        r_d.st     = S_IDLE;
        r_d.rounds = r_q.rounds + 8'h01;
      end else begin
        r_d.slot  = r_q.slot + 2'h1;
        r_d.order = order_of(r_q.slot + 2'h1, r_q.idx);
        r_d.st    = S_REQ;
      end
    end
    if (go_div || go_sqrt) begin
      r_d.st   = go_div ? S_DIV : S_SQRT;
      r_d.num  = nxt_num;
      r_d.den  = nxt_den;
      r_d.op   = nxt_op;
      r_d.rem  = '0;
      r_d.root = '0;
      r_d.cnt  = '0;
    end
    // A new channel, time base or order set invalidates the round in flight.
    if (restart) r_d.st = S_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q        <= '0;
      r_q.cfg    <= CFG_RST;
      r_q.idx[0] <= IDX0_RST;
      r_q.idx[1] <= IDX1_RST;
      r_q.idx[2] <= IDX2_RST;
      r_q.st     <= S_IDLE;
      r_q.op     <= OP_FREQ;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata                  = r_q.rdata;
  assign time_base_phase_select  = r_q.cfg[CFG_TB_LSB +: 2];
  assign analysed_channel_select = r_q.cfg[CFG_CH_LSB +: 2];
  assign comp_req                = (r_q.st == S_REQ);
  assign comp_order              = r_q.order;

endmodule : hae_engine

// ---- hae_pkg.sv ----
// Purpose: Shared constants and types of the harmonic analysis engine.
// Assumes: APB slave with 12-bit byte addresses and 32-bit data.
// Notes:   Results are 24-bit words in the low bits of each register.

package hae_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CFG       = 12'h000;
  localparam logic [11:0] ADDR_IDX0      = 12'h004;
  localparam logic [11:0] ADDR_IDX1      = 12'h008;
  localparam logic [11:0] ADDR_IDX2      = 12'h00C;
  localparam logic [11:0] ADDR_STATUS    = 12'h010;
  localparam logic [11:0] ADDR_POFF      = 12'h020;
  localparam logic [11:0] ADDR_POFF_LAST = 12'h034;
  localparam logic [11:0] ADDR_HOFF      = 12'h040;
  localparam logic [11:0] ADDR_HOFF_LAST = 12'h054;
  localparam logic [4:0]  RES_PAGE       = 5'h01;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          CFG_TB_LSB   = 8;
  localparam int          CFG_CH_LSB   = 1;
  localparam logic [15:0] CFG_WMASK    = 16'h0306;
  localparam logic [15:0] CFG_RST      = 16'h0000;
  localparam logic [1:0]  CH_NEUTRAL   = 2'b11;
  localparam logic [7:0]  IDX_MAX      = 8'h3F;
  localparam logic [7:0]  IDX0_RST     = 8'h02;
  localparam logic [7:0]  IDX1_RST     = 8'h03;
  localparam logic [7:0]  IDX2_RST     = 8'h05;
  localparam logic [5:0]  ORDER_FUND   = 6'h01;
  localparam logic [5:0]  N_MAX        = 6'h3F;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_IN_RANGE  = 1;
  localparam int          ST_BEYOND    = 2;
  localparam int          ST_N_LSB     = 8;
  localparam int          ST_ROUND_LSB = 16;

  // Result words inside each slot page; slot 0 is the fundamental.
  localparam logic [2:0]  F_VRMS = 3'h0;
  localparam logic [2:0]  F_IRMS = 3'h1;
  localparam logic [2:0]  F_P    = 3'h2;
  localparam logic [2:0]  F_Q    = 3'h3;
  localparam logic [2:0]  F_S    = 3'h4;
  localparam logic [2:0]  F_PF   = 3'h5;
  localparam logic [2:0]  F_HDV  = 3'h6;
  localparam logic [2:0]  F_HDI  = 3'h7;

  // ---------------------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------------------
  localparam int          PASSBAND_HZ  = 2800;
  localparam int          FREQ_FRAC    = 8;
  localparam int          FREQ_MIN_HZ  = 45;
  localparam int          FREQ_MAX_HZ  = 66;
  localparam logic [15:0] FREQ_MIN     = 16'(FREQ_MIN_HZ * (2 ** FREQ_FRAC));
  localparam logic [15:0] FREQ_MAX     = 16'(FREQ_MAX_HZ * (2 ** FREQ_FRAC));
  localparam logic [47:0] FREQ_DIV_NUM = 48'(PASSBAND_HZ * (2 ** FREQ_FRAC));
  localparam logic [23:0] HD_ONE       = 24'h1F_FFFF;
  localparam logic [23:0] RES_MAX      = 24'h7F_FFFF;
  localparam logic [5:0]  DIV_STEPS    = 6'h30;
  localparam logic [5:0]  SQRT_STEPS   = 6'h18;

  typedef enum logic [2:0] {S_IDLE, S_REQ, S_POWER, S_DIV, S_SQRT} hae_state_type;
  typedef enum logic [2:0] {OP_FREQ, OP_PF, OP_HDV, OP_HDI, OP_THDV, OP_THDI} hae_op_type;

endpackage : hae_pkg

// ---- hae_engine_chk.sv ----
// Purpose: Bus and component-link properties of the harmonic engine.
// Assumes: Sees only the engine ports; one clock domain.
// Notes:   Bound into every engine instance at the foot of this file.
`timescale 1ns/10ps
module hae_engine_chk
  import hae_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [1:0]  time_base_phase_select,
  input wire logic [1:0]  analysed_channel_select,
  input wire logic        comp_req,
  input wire logic [5:0]  comp_order,
  input wire logic        comp_valid
);
  // ---------------------------------------------------------------------------
  // Helpers and properties
  // ---------------------------------------------------------------------------
  logic [31:0] wdata_q;
  logic        cfg_wr;
  logic        idx_wr;
  logic        phase_mode;
  assign cfg_wr = psel && penable && pwrite && (paddr == ADDR_CFG);
  // A neutral round with index 0 not 1 moves straight on to the next slot, so only phase mode always drops the request.
  assign phase_mode = (analysed_channel_select != CH_NEUTRAL);
  assign idx_wr = psel && penable && pwrite &&
                  (paddr == ADDR_IDX0 || paddr == ADDR_IDX1 || paddr == ADDR_IDX2);
  // Last write word, so the select outputs can be tied to what software wrote.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_q <= '0;
    end else begin
      wdata_q <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tb_select: assert property (cfg_wr |=> time_base_phase_select == wdata_q[9:8])
    else $error("time base select does not follow config write");
  a_ch_select: assert property (cfg_wr |=> analysed_channel_select == wdata_q[2:1])
    else $error("analysed channel does not follow config write");
  a_idx_refuse: assert property (idx_wr && pwdata[7:0] > IDX_MAX |-> pslverr)
    else $error("index above limit not refused");
  a_idx_accept: assert property (idx_wr && pwdata[7:0] <= IDX_MAX |-> !pslverr)
    else $error("legal index write refused");
  a_req_hold: assert property (comp_req && !comp_valid && !(psel && pwrite) |=>
                               comp_req && $stable(comp_order))
    else $error("component request dropped or changed");
  a_req_drop: assert property (comp_req && comp_valid && phase_mode |=> !comp_req)
    else $error("component request stays after answer");
  a_cfg_abort: assert property (cfg_wr |-> ##[1:2] !comp_req)
    else $error("config write did not restart the round");
  a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not flagged");
endmodule : hae_engine_chk

bind hae_engine hae_engine_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .time_base_phase_select(time_base_phase_select),
  .analysed_channel_select(analysed_channel_select),
  .comp_req(comp_req), .comp_order(comp_order), .comp_valid(comp_valid)
);

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the harmonic engine over APB.
// Assumes: Bench answers component requests with fixed data by order.
// Notes:   Results are read after two completed rounds.
`timescale 1ns/10ps
module tb_top
  import hae_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------------------
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} hae_exp_type;
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr;
  logic              comp_req;
  logic              comp_valid = 1'b0;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd_data;
  logic [15:0]       line_freq;
  logic [1:0]        tbs, chs;
  logic [1:0]        dly = 2'd0;
  logic [5:0]        comp_order;
  logic [23:0]       comp_vrms = '0, comp_irms = '0, comp_p = '0, comp_q = '0;
  logic [7:0]        r;
  integer            seed = 32'hfa38;
  int                error_cnt, total_checks;
  hae_exp_type       exp_q[$];
  logic [31:0]       ph[13] = '{32'h0030_0000, 32'h0110_0000, 32'h0203_0000, 32'h0406_0000,
    32'h0540_0000, 32'h062A_AAAA, 32'h0700_0000, 32'h100C_0010, 32'h117F_FFFF,
    32'h1500_0000, 32'h1608_000A, 32'h177F_FFFF, 32'h3030_0000};
  logic [31:0]       nt[6] = '{32'h1030_0000, 32'h161F_FFFF, 32'h171F_FFFF,
    32'h200C_0000, 32'h2608_0000, 32'h277F_FFFF};
  hae_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_freq(line_freq), .time_base_phase_select(tbs),
    .analysed_channel_select(chs), .comp_req(comp_req), .comp_order(comp_order),
    .comp_valid(comp_valid), .comp_vrms(comp_vrms), .comp_irms(comp_irms),
    .comp_p(comp_p), .comp_q(comp_q), .total_vrms(24'h50_0000), .total_irms(24'h10_0000));
  always #4 pclk = ~pclk;
  // ---------------------------------------------------------------------------
  // Tasks, responder and monitor
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    exp_q.push_back('{d, m, e});
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Waits until the round counter has moved by two, so results reflect current settings.
  task automatic rounds2();
    logic [7:0] b;
    int n;
    apb(0, ADDR_STATUS, 0, 0, 0);
    @(negedge pclk);
    b = rd_data[23:16];
    n = 0;
    do begin
      repeat (50) @(posedge pclk);
      apb(0, ADDR_STATUS, 0, 0, 0);
      @(negedge pclk);
      n++;
    end while (8'(rd_data[23:16] - b) < 8'd2 && n < 200);
    check(32'(n < 200), 32'd1);
  endtask : rounds2
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    if (comp_valid) begin
      comp_valid <= 1'b0;
    end else if (comp_req === 1'b1) begin
      if (dly == 2'd0) begin
        comp_valid <= 1'b1;
        comp_vrms  <= (comp_order == ORDER_FUND) ? 24'h30_0000 : 24'h0C_0000;
        comp_irms  <= (comp_order == ORDER_FUND) ? 24'h10_0000 : 24'h7F_FFFF;
        comp_p     <= (comp_order == ORDER_FUND) ? 24'h03_0000 : 24'h00_0000;
        comp_q     <= (comp_order == ORDER_FUND) ? 24'h01_0000 : 24'h00_0000;
        dly        <= 2'($random(seed));
      end else begin
        dly <= dly - 2'd1;
      end
    end
  end
  always @(posedge pclk) begin
    hae_exp_type e;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      rd_data = prdata;
      check(32'(pslverr), 32'(e.e));
      if (!pwrite) check(prdata & e.m, e.d & e.m);
    end
  end
  initial begin
    repeat (80000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    int hz[4] = '{50, 45, 66, 40};
    int nn[4] = '{56, 62, 42, 63};
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    line_freq = 16'h3200;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CFG, 32'(CFG_RST), '1, 0);
    apb(0, ADDR_IDX0, 32'(IDX0_RST), '1, 0);
    apb(0, ADDR_IDX1, 32'(IDX1_RST), '1, 0);
    apb(0, ADDR_IDX2, 32'(IDX2_RST), '1, 0);
    for (int i = 0; i < 6; i++) begin
      apb(0, ADDR_POFF + 12'(4 * i), 0, '1, 0);
      apb(0, ADDR_HOFF + 12'(4 * i), 0, '1, 0);
    end
    for (int t = 0; t < 3; t++) for (int c = 0; c < 4; c++) begin
      apb(1, ADDR_CFG, 32'(t << 8 | c << 1), 0, 0);
      apb(0, ADDR_CFG, 32'(t << 8 | c << 1), 32'h0000_0306, 0);
      @(negedge pclk);
      check(32'(tbs), 32'(t));
      check(32'(chs), 32'(c));
    end
    r = 8'(($unsigned($random(seed)) % 63) + 1);
    apb(1, ADDR_IDX0, 32'h0000_0040, 0, 1);
    apb(0, ADDR_IDX0, 32'(IDX0_RST), '1, 0);
    apb(1, ADDR_IDX1, 32'h0000_003F, 0, 0);
    apb(0, ADDR_IDX1, 32'h0000_003F, '1, 0);
    apb(1, ADDR_IDX2, 32'(r), 0, 0);
    apb(0, ADDR_IDX2, 32'(r), '1, 0);
    apb(1, 12'h002, 0, 0, 1);
    apb(0, 12'h018, 0, '1, 1);
    apb(1, ADDR_CFG, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      line_freq <= 16'(hz[i] << 8);
      rounds2();
      apb(0, ADDR_STATUS, 32'(nn[i] << 8 | (i < 3) << 1), 32'h0000_3F02, 0);
    end
    line_freq <= 16'h3200;
    apb(1, ADDR_IDX0, 2, 0, 0);
    apb(1, ADDR_IDX1, 3, 0, 0);
    apb(1, ADDR_IDX2, 1, 0, 0);
    apb(1, ADDR_HOFF, 32'h0000_0010, 0, 0);
    rounds2();
    foreach (ph[i]) apb(0, {RES_PAGE, ph[i][29:28], ph[i][26:24], 2'b00},
      {8'h0, ph[i][23:0]}, 32'h00FF_FFFF, 0);
    apb(1, ADDR_HOFF, 0, 0, 0);
    apb(1, ADDR_IDX0, 1, 0, 0);
    apb(1, ADDR_IDX2, 4, 0, 0);
    apb(1, ADDR_CFG, 32'h0000_0006, 0, 0);
    rounds2();
    foreach (nt[i]) apb(0, {RES_PAGE, nt[i][29:28], nt[i][26:24], 2'b00},
      {8'h0, nt[i][23:0]}, 32'h00FF_FFFF, 0);
    tally_and_finish();
  end
endmodule : tb_top
